/* hdl/dual_half_multiplier.sv */
`timescale 1ns/100ps
`default_nettype none
module dual_half_multiplier
    import mac_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Request.
    input wire logic load,
    input wire mul_req_type req,
    // Signed product term, ready one edge after load.
    output logic [63:0] term_reg
);

    logic signed [15:0] a_top;
    logic signed [15:0] a_bot;
    logic signed [15:0] b_for_top;
    logic signed [15:0] b_for_bot;
    logic signed [31:0] p_top;
    logic signed [31:0] p_bot;
    logic signed [31:0] p_half;
    logic a_sel_top;
    logic b_sel_top;
    logic signed [63:0] word_prod;
    logic [63:0] term_next;

    // Halfword pairing, straight or crossed.
    always_comb begin
        a_top = req.a[31:16];
        a_bot = req.a[15:0];
        b_for_top = half_of(req.b, !op_crossed(req.op));
        b_for_bot = half_of(req.b, op_crossed(req.op));
        p_top = a_top * b_for_top;
        p_bot = a_bot * b_for_bot;
        // Select letters: the first names the first operand's half.
        a_sel_top = req.op inside {OP_LONG_HALF_MAC_TOP_BOTTOM,
                                   OP_LONG_HALF_MAC_TOP_TOP};
        b_sel_top = req.op inside {OP_LONG_HALF_MAC_BOTTOM_TOP,
                                   OP_LONG_HALF_MAC_TOP_TOP};
        p_half = $signed(half_of(req.a, a_sel_top)) *
                 $signed(half_of(req.b, b_sel_top));
        word_prod = $signed({{32{req.a[31]}}, req.a}) *
                    $signed({{32{req.b[31]}}, req.b});
    end

    // The product term per operation; none of these can overflow.
    always_comb begin
        unique case (req.op)
            OP_LONG_WORD_MAC: term_next = word_prod;
            OP_LONG_HALF_MAC_BOTTOM_BOTTOM, OP_LONG_HALF_MAC_BOTTOM_TOP,
            OP_LONG_HALF_MAC_TOP_BOTTOM, OP_LONG_HALF_MAC_TOP_TOP: begin
                term_next = {{32{p_half[31]}}, p_half};
            end
            OP_DUAL_MSUB_32, OP_DUAL_MSUB_32_CROSSED, OP_DUAL_MSUB_64,
            OP_DUAL_MSUB_64_CROSSED: begin
                term_next = {{32{p_bot[31]}}, p_bot} -
                            {{32{p_top[31]}}, p_top};
            end
            default: term_next = {{32{p_top[31]}}, p_top} +
                                 {{32{p_bot[31]}}, p_bot};
        endcase
    end

    // Product register cuts the multiplier off from the adder path.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_reg <= TERM_RESET;
        end else if (load) begin
            term_reg <= term_next;
        end
    end

endmodule : dual_half_multiplier
`default_nettype wire

/* hdl/signed_dual_mac_datapath.sv */
`timescale 1ns/100ps
`default_nettype none
module signed_dual_mac_datapath
    import mac_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sticky saturation flag for the core.
    output logic sat_flag
);

    // Operand and accumulator registers.
    logic [31:0] first_operand_reg;
    logic [31:0] second_operand_reg;
    logic [31:0] accumulate_reg;
    logic [31:0] acc_high_reg;
    logic [31:0] dest_low_word_reg;
    logic [31:0] dest_high_word_reg;
    logic [3:0] op_reg;
    logic sat_reg;

    // Bus handshake state.
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    // Sequencer.
    seq_state_type state_reg;
    seq_state_type state_next;

    // Decoded strobes.
    logic access;
    logic wr_done;
    logic idle;
    logic start;
    logic sat_clear;
    logic sat_set;
    logic acc_load;

    // Datapath wiring.
    mul_req_type mul_req;
    logic [63:0] term;
    acc_out_type acc_out;

    assign idle = state_reg == ST_IDLE;

    // A request is taken in the first access cycle; pready answers one
    // cycle later so that read data and the error flag come from flops.
    assign access = psel && penable && !pready_reg;

    // A write takes effect only at the edge that completes the transfer,
    // and never for an unmapped address.
    assign wr_done = psel && penable && pready_reg && pwrite && !pslverr_reg;

    // Control writes while a calculation runs are dropped, so that the
    // operands cannot change under the pipeline.
    assign start = wr_done && idle && paddr == CTRL_OFS &&
                   pwdata[CTRL_START_BIT] &&
                   op_legal(pwdata[CTRL_OP_LSB +: 4]);

    // Software clears the saturation flag by writing one to its bit.
    assign sat_clear = wr_done && paddr == STATUS_OFS &&
                       pwdata[STATUS_SAT_BIT];

    // Only the subtract forms report an overflow of the accumulate step.
    assign sat_set = state_reg == ST_ACCUM && op_msub(op_reg) &&
                     acc_out.ovf;

    // The low result word, and for the 64-bit forms the high result word and the accumulator pair, are written back in the last pipeline step.
    assign acc_load = state_reg == ST_ACCUM;

    // Operand bundle for the multiplier.
    always_comb begin
        mul_req.op = op_reg;
        mul_req.a = first_operand_reg;
        mul_req.b = second_operand_reg;
    end

    // Handshake answer one cycle after the request is taken.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= access;
        end
    end

    // Unmapped addresses answer with an error and read as zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_reg <= 1'b0;
        end else begin
            pslverr_reg <= access && !reg_mapped(paddr);
        end
    end

    // Read multiplexer.
    always_comb begin
        prdata_next = WORD_RESET;
        unique case (paddr)
            OPERAND_A_OFS: prdata_next = first_operand_reg;
            OPERAND_B_OFS: prdata_next = second_operand_reg;
            ACC_LO_OFS: prdata_next = accumulate_reg;
            ACC_HI_OFS: prdata_next = acc_high_reg;
            CTRL_OFS: prdata_next[CTRL_OP_LSB +: 4] = op_reg;
            STATUS_OFS: begin
                prdata_next[STATUS_SAT_BIT] = sat_reg;
                prdata_next[STATUS_BUSY_BIT] = !idle;
            end
            RESULT_LO_OFS: prdata_next = dest_low_word_reg;
            RESULT_HI_OFS: prdata_next = dest_high_word_reg;
            default: prdata_next = WORD_RESET;
        endcase
    end

    // Read data is captured when the request is taken and held until
    // the next request, which keeps prdata stable while pready is high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= WORD_RESET;
        end else if (access) begin
            prdata_reg <= pwrite ? WORD_RESET : prdata_next;
        end
    end

    // First and second operand registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_operand_reg <= WORD_RESET;
            second_operand_reg <= WORD_RESET;
        end else if (wr_done && idle) begin
            if (paddr == OPERAND_A_OFS) begin
                first_operand_reg <= pwdata;
            end
            if (paddr == OPERAND_B_OFS) begin
                second_operand_reg <= pwdata;
            end
        end
    end

    // Operation code; an illegal code is stored but never started.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_reg <= OP_DUAL_MAC_32;
        end else if (wr_done && idle && paddr == CTRL_OFS) begin
            op_reg <= pwdata[CTRL_OP_LSB +: 4];
        end
    end

    // Accumulate pair: written by software, or by the 64-bit forms with
    // their wrapped sum. The 32-bit forms only read the low word.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accumulate_reg <= WORD_RESET;
            acc_high_reg <= WORD_RESET;
        end else if (acc_load && op_wide(op_reg)) begin
            accumulate_reg <= acc_out.sum[31:0];
            acc_high_reg <= acc_out.sum[63:32];
        end else if (wr_done && idle) begin
            if (paddr == ACC_LO_OFS) begin
                accumulate_reg <= pwdata;
            end
            if (paddr == ACC_HI_OFS) begin
                acc_high_reg <= pwdata;
            end
        end
    end

    // Destination words. The high and low words are separate registers
    // by construction, so the pair can never alias.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dest_low_word_reg <= WORD_RESET;
            dest_high_word_reg <= WORD_RESET;
        end else if (acc_load) begin
            dest_low_word_reg <= acc_out.sum[31:0];
            if (op_wide(op_reg)) begin
                dest_high_word_reg <= acc_out.sum[63:32];
            end
        end
    end

    // Saturation flag: a set in the same cycle as a clear wins, and a
    // calculation without overflow leaves it as it is.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sat_reg <= 1'b0;
        end else if (sat_set) begin
            sat_reg <= 1'b1;
        end else if (sat_clear) begin
            sat_reg <= 1'b0;
        end
    end

    // Sequencer next state.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (start) begin
                    state_next = ST_MULT;
                end
            end
            ST_MULT: state_next = ST_ACCUM;
            ST_ACCUM: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // Sequencer state register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Products are formed one cycle after the start, from the operands
    // that the sequencer has frozen.
    dual_half_multiplier mul_unit (
        .pclk(pclk),
        .presetn(presetn),
        .load(state_reg == ST_MULT),
        .req(mul_req),
        .term_reg(term)
    );

    // The adder sees the product term and the accumulate pair.
    wide_accumulator acc_unit (
        .term(term),
        .acc({acc_high_reg, accumulate_reg}),
        .wide(op_wide(op_reg)),
        .result(acc_out)
    );

    // Outputs come straight from flops.
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign sat_flag = sat_reg;

endmodule : signed_dual_mac_datapath
`default_nettype wire

/* hdl/wide_accumulator.sv */
`timescale 1ns/100ps
`default_nettype none
module wide_accumulator
    import mac_pkg::*;
(
    // Operands.
    input wire logic [63:0] term,
    input wire logic [63:0] acc,
    input wire logic wide,
    // Wrapped sum with signed overflow.
    output acc_out_type result
);

    logic [64:0] sum65;
    logic [32:0] sum33;

    // Sums wrap at the destination width; overflow is only reported.
    always_comb begin
        sum65 = {acc[63], acc} + {term[63], term};
        sum33 = {acc[31], acc[31:0]} + {term[31], term[31:0]};
        if (wide) begin
            result.sum = sum65[63:0];
            result.ovf = sum65[64] ^ sum65[63];
        end else begin
            result.sum = {acc[63:32], sum33[31:0]};
            result.ovf = sum33[32] ^ sum33[31];
        end
    end

endmodule : wide_accumulator
`default_nettype wire

/* inc/mac_pkg.sv */
package mac_pkg;

    // Register byte offsets on the APB port; each register is one word.
    localparam logic [7:0] OPERAND_A_OFS = 8'h00;
    localparam logic [7:0] OPERAND_B_OFS = 8'h04;
    localparam logic [7:0] ACC_LO_OFS = 8'h08;
    localparam logic [7:0] ACC_HI_OFS = 8'h0c;
    localparam logic [7:0] CTRL_OFS = 8'h10;
    localparam logic [7:0] STATUS_OFS = 8'h14;
    localparam logic [7:0] RESULT_LO_OFS = 8'h18;
    localparam logic [7:0] RESULT_HI_OFS = 8'h1c;

    // Field positions.
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_START_BIT = 8;
    localparam int STATUS_SAT_BIT = 0;
    localparam int STATUS_BUSY_BIT = 1;

    // Values after reset.
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [63:0] TERM_RESET = 64'h0000_0000_0000_0000;

    // Operation codes held in the control register.
    localparam logic [3:0] OP_DUAL_MAC_32 = 4'h0;
    localparam logic [3:0] OP_DUAL_MAC_32_CROSSED = 4'h1;
    localparam logic [3:0] OP_LONG_WORD_MAC = 4'h2;
    localparam logic [3:0] OP_LONG_HALF_MAC_BOTTOM_BOTTOM = 4'h3;
    localparam logic [3:0] OP_LONG_HALF_MAC_BOTTOM_TOP = 4'h4;
    localparam logic [3:0] OP_LONG_HALF_MAC_TOP_BOTTOM = 4'h5;
    localparam logic [3:0] OP_LONG_HALF_MAC_TOP_TOP = 4'h6;
    localparam logic [3:0] OP_DUAL_MAC_64 = 4'h7;
    localparam logic [3:0] OP_DUAL_MAC_64_CROSSED = 4'h8;
    localparam logic [3:0] OP_DUAL_MSUB_32 = 4'h9;
    localparam logic [3:0] OP_DUAL_MSUB_32_CROSSED = 4'ha;
    localparam logic [3:0] OP_DUAL_MSUB_64 = 4'hb;
    localparam logic [3:0] OP_DUAL_MSUB_64_CROSSED = 4'hc;

    // Sequencer states, one-hot.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_MULT = 3'b010,
        ST_ACCUM = 3'b100
    } seq_state_type;

    // Operation and operands handed to the multiplier.
    typedef struct packed {
        logic [3:0] op;
        logic [31:0] a;
        logic [31:0] b;
    } mul_req_type;

    // Accumulator answer: wrapped sum and signed overflow.
    typedef struct packed {
        logic [63:0] sum;
        logic ovf;
    } acc_out_type;

    function automatic logic op_legal(input logic [3:0] op);
        return op <= OP_DUAL_MSUB_64_CROSSED;
    endfunction : op_legal

    function automatic logic op_crossed(input logic [3:0] op);
        return op inside {OP_DUAL_MAC_32_CROSSED, OP_DUAL_MAC_64_CROSSED,
                          OP_DUAL_MSUB_32_CROSSED, OP_DUAL_MSUB_64_CROSSED};
    endfunction : op_crossed

    function automatic logic op_msub(input logic [3:0] op);
        return op inside {OP_DUAL_MSUB_32, OP_DUAL_MSUB_32_CROSSED,
                          OP_DUAL_MSUB_64, OP_DUAL_MSUB_64_CROSSED};
    endfunction : op_msub

    function automatic logic op_wide(input logic [3:0] op);
        return !(op inside {OP_DUAL_MAC_32, OP_DUAL_MAC_32_CROSSED,
                            OP_DUAL_MSUB_32, OP_DUAL_MSUB_32_CROSSED});
    endfunction : op_wide

    // Picks bits [31:16] when top is set, else bits [15:0].
    function automatic logic [15:0] half_of(input logic [31:0] w,
                                            input logic top);
        return top ? w[31:16] : w[15:0];
    endfunction : half_of

    function automatic logic reg_mapped(input logic [7:0] addr);
        return addr[1:0] == 2'b00 && addr <= RESULT_HI_OFS;
    endfunction : reg_mapped

endpackage : mac_pkg

/* test/apb_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module apb_host_model
    import mac_pkg::*;
(
    // Clock.
    input wire logic pclk,
    // Request.
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    // Answer.
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Bus idle at time zero.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // One transfer, entered just after a rising edge. The request stands
    // until the rising edge at which pready is seen high; the answer is
    // taken at that same edge, and only then is the bus released.
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic e, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        r = ~d;
        e = 1'b1;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        while (!ok && n < 16) begin
            @(posedge pclk);
            ok = pready === 1'b1;
            n++;
        end
        r = prdata;
        e = pslverr;
        // Released lines carry the inverse so stale values never pass.
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge pclk);
    endtask : xfer

    // The pair halves live at two distinct offsets.
    task automatic write_pair(input logic [63:0] v, output logic ok);
        logic [31:0] r;
        logic e;
        logic ok_lo;
        xfer(ACC_LO_OFS, 1'b1, v[31:0], r, e, ok_lo);
        xfer(ACC_HI_OFS, 1'b1, v[63:32], r, e, ok);
        ok = ok && ok_lo;
    endtask : write_pair
endmodule : apb_host_model
`default_nettype wire

/* test/signed_dual_mac_datapath_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module signed_dual_mac_datapath_asserts
    import mac_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Saturation flag.
    input wire logic sat_flag
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic done;
    logic in_access;
    logic sat_clr;
    logic msub_go;
    logic [3:0] msub_hist_reg;

    // Completed transfers, a saturation clear and a subtract-form start.
    assign done = psel && penable && pready;
    assign in_access = psel && penable;
    assign sat_clr = done && pwrite && paddr == STATUS_OFS && pwdata[0];
    assign msub_go = done && pwrite && paddr == CTRL_OFS && pwdata[8]
        && pwdata[3:0] >= OP_DUAL_MSUB_32
        && pwdata[3:0] <= OP_DUAL_MSUB_64_CROSSED;

    // Recent subtract starts; a set flag must trace back to one of them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msub_hist_reg <= 4'h0;
        end else begin
            msub_hist_reg <= {msub_hist_reg[2:0], msub_go};
        end
    end

    chk_ready_one_pulse: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    chk_ready_cause: assert property ($rose(pready) |->
        $past(in_access)) else $error("pready without access phase");
    chk_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("access phase not answered after one wait state");
    chk_err_unmapped: assert property (pready && (paddr > RESULT_HI_OFS
        || paddr[1:0] != 2'b00) |-> pslverr && prdata == WORD_RESET)
        else $error("unmapped access not refused");
    chk_ok_mapped: assert property (pready && paddr <= RESULT_HI_OFS
        && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    chk_ctrl_high_zero: assert property (pready && !pwrite
        && paddr == CTRL_OFS |-> prdata[31:4] == 28'h0000000)
        else $error("control register read has bits above the op code");
    chk_sat_only_sub: assert property (
        $rose(sat_flag) |-> |msub_hist_reg)
        else $error("saturation set without a subtract form");
    chk_sat_sticky: assert property (
        sat_flag && !sat_clr |=> sat_flag)
        else $error("saturation dropped without a clear");
    chk_sat_clears: assert property (sat_clr && !(|msub_hist_reg)
        |=> !sat_flag) else $error("saturation clear ignored");

    cover property ($rose(sat_flag));
    cover property ($fell(sat_flag));
    cover property (pready && pslverr);
    cover property (msub_go);
endmodule : signed_dual_mac_datapath_asserts

bind signed_dual_mac_datapath signed_dual_mac_datapath_asserts u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sat_flag(sat_flag)
);
`default_nettype wire

/* test/signed_dual_mac_datapath_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module signed_dual_mac_datapath_tb
    import mac_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic sat_flag, sat_seen, sat_exp;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    int error_cnt, checks_done;

    signed_dual_mac_datapath u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sat_flag(sat_flag));
    apb_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    // Clock, and a settled copy of the flag taken away from the edge.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(negedge pclk) sat_seen = sat_flag;

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    task automatic cmp(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d, input logic e_exp,
                       output logic [31:0] r);
        logic e, ok;
        u_host.xfer(a, w, d, r, e, ok);
        if (!ok) begin
            error_cnt++;
            $display("unexpected pready: expected 1, seen 0");
            give_verdict();
        end
        cmp("pslverr", {31'h0, e_exp}, {31'h0, e});
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, 1'b0, r);
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [31:0] exp);
        logic [31:0] r;
        bus(a, 1'b0, 32'h0, 1'b0, r);
        cmp(what, exp, r);
    endtask : rd_chk

    // Reference arithmetic worked out independently of the design.
    function automatic logic [64:0] ref_calc(input logic [3:0] op,
        input logic [31:0] a, input logic [31:0] b, input logic [63:0] acc);
        logic signed [15:0] bh, bl;
        logic signed [63:0] t, s;
        logic x, ov;
        x = op inside {OP_DUAL_MAC_32_CROSSED, OP_DUAL_MAC_64_CROSSED,
                       OP_DUAL_MSUB_32_CROSSED, OP_DUAL_MSUB_64_CROSSED};
        bh = x ? b[15:0] : b[31:16];
        bl = x ? b[31:16] : b[15:0];
        if (op == OP_LONG_WORD_MAC) begin
            t = $signed(a) * $signed(b);
        end else if (op >= 4'h3 && op <= 4'h6) begin
            t = $signed(op >= 4'h5 ? a[31:16] : a[15:0])
                * $signed(op[0] ? b[15:0] : b[31:16]);
        end else if (op >= OP_DUAL_MSUB_32) begin
            t = $signed(a[15:0]) * bl - $signed(a[31:16]) * bh;
        end else begin
            t = $signed(a[31:16]) * bh + $signed(a[15:0]) * bl;
        end
        if (op inside {4'h0, 4'h1, 4'h9, 4'ha}) begin
            s = {32'h0, acc[31:0] + t[31:0]};
            ov = acc[31] == t[31] && s[31] != acc[31];
        end else begin
            s = acc + t;
            ov = acc[63] == t[63] && s[63] != acc[63];
        end
        return {ov, s};
    endfunction : ref_calc

    // Loads operands, starts one operation and checks every result word.
    task automatic run_op(input logic [3:0] op, input logic [31:0] a,
                          input logic [31:0] b, input logic [63:0] acc);
        logic [64:0] m;
        logic [31:0] r;
        logic ok;
        int n;
        m = ref_calc(op, a, b, acc);
        sat_exp = sat_exp | (m[64] && op >= OP_DUAL_MSUB_32);
        wr(OPERAND_A_OFS, a);
        wr(OPERAND_B_OFS, b);
        u_host.write_pair(acc, ok);
        cmp("pair write", 32'h1, {31'h0, ok});
        wr(CTRL_OFS, 32'h0000_0100 | {28'h0, op});
        r = 32'h2;
        for (n = 0; n < 8 && r[1] !== 1'b0; n++) begin
            bus(STATUS_OFS, 1'b0, 32'h0, 1'b0, r);
        end
        cmp("status", {30'h0, 1'b0, sat_exp}, r);
        rd_chk("result_lo", RESULT_LO_OFS, m[31:0]);
        if (op inside {4'h0, 4'h1, 4'h9, 4'ha}) begin
            rd_chk("acc_lo", ACC_LO_OFS, acc[31:0]);
        end else begin
            rd_chk("result_hi", RESULT_HI_OFS, m[63:32]);
            rd_chk("acc_lo", ACC_LO_OFS, m[31:0]);
            rd_chk("acc_hi", ACC_HI_OFS, m[63:32]);
        end
        cmp("sat_flag", {31'h0, sat_exp}, {31'h0, sat_seen});
    endtask : run_op

    // Every operation code with one operand set.
    task automatic test_ops(input logic [31:0] a, input logic [31:0] b,
                            input logic [63:0] acc);
        for (int op = 0; op <= 12; op++) begin
            run_op(op[3:0], a, b, acc);
        end
        $display("test ops %h %h %h done", a, b, acc);
    endtask : test_ops

    // All registers read zero after reset.
    task automatic test_reset();
        for (int i = 0; i < 8; i++) begin
            rd_chk("reset word", 8'(4 * i), WORD_RESET);
        end
        cmp("sat_flag", 32'h0, {31'h0, sat_seen});
        $display("test reset done");
    endtask : test_reset

    // A clear of zero and a quiet add keep the flag; a clear of one drops it.
    task automatic test_sat_clear();
        wr(STATUS_OFS, 32'h0);
        run_op(OP_DUAL_MAC_32, 32'h8000_7fff, 32'h7ffe_8001, 64'h0);
        wr(STATUS_OFS, 32'h1);
        sat_exp = 1'b0;
        rd_chk("status", STATUS_OFS, 32'h0);
        $display("test sat clear done");
    endtask : test_sat_clear

    // Unmapped and unaligned places, a control read-back and a bad opcode.
    task automatic test_refusals(input logic [64:0] last);
        logic [31:0] r;
        bus(8'h20, 1'b0, 32'h0, 1'b1, r);
        cmp("unmapped read", 32'h0, r);
        bus(8'h06, 1'b1, 32'h1234_5678, 1'b1, r);
        bus(8'h05, 1'b0, 32'h0, 1'b1, r);
        rd_chk("ctrl", CTRL_OFS, {28'h0, OP_DUAL_MSUB_64_CROSSED});
        wr(CTRL_OFS, 32'h0000_010d);
        rd_chk("status", STATUS_OFS, {31'h0, sat_exp});
        rd_chk("result_lo", RESULT_LO_OFS, last[31:0]);
        $display("test refusals done");
    endtask : test_refusals

    initial begin
        error_cnt = 0;
        checks_done = 0;
        sat_exp = 1'b0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        test_reset();
        test_ops(32'h8000_7fff, 32'h7ffe_8001, 64'hffff_ffff_ffff_fff0);
        test_ops(32'h0001_8000, 32'h0001_8000, 64'h7fff_ffff_ffff_ffff);
        test_sat_clear();
        test_ops(32'h0001_8000, 32'h0001_8000, 64'h0000_0000_7fff_ffff);
        test_refusals(ref_calc(OP_DUAL_MSUB_64_CROSSED, 32'h0001_8000,
            32'h0001_8000, 64'h0000_0000_7fff_ffff));
        give_verdict();
    end
endmodule : signed_dual_mac_datapath_tb
`default_nettype wire
